// ### rtl/ctx_debug_regs.sv
/*
 * Debug and status register group of the serial video transmitter:
 * lane override, sync, header and checksum fault controls, activity state,
 * vendor and version words, and the fault injector on the packet path.
 * Assumes a zero-wait register port in the pixel clock domain and a packet
 * builder that presents one packet's protected fields per valid cycle.
 */
`timescale 1ns/100ps
`include "ctx_map.svh"

module ctx_debug_regs #(
    parameter int LANES = 4,
    parameter bit DEBUG = 1'b1,
    // arbitrary neutral identity values
    parameter logic [31:0] VENDOR_CODE = 32'h00005A5A,
    parameter logic [31:0] VERSION_CODE = 32'h00010000
) (
    // clock, reset, enable
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // register port
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // transmitter activity
    input wire logic [2:0] TX_STATE,
    // packet path
    input wire ctx_pkg::ctx_pkt_s PKT_IN,
    output ctx_pkg::ctx_pkt_s PKT_OUT,
    // lane forcing to the analog lanes
    output logic [31:0] LANE_OVERRIDE
);

    // ----------------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------------
    if (LANES < 1 || LANES > 4)
    begin : g_bad_lanes
        $error("LANES must lie between 1 and 4");
    end

    // ----------------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------------
    logic [31:0] sync_fault_inject_ctrl;
    logic [31:0] header_fault_inject_ctrl;
    logic [31:0] line_checksum_fault_ctrl;
    logic [2:0] activity_state;
    logic [2:0] prev_tx_state;

    // ----------------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------------
    wire logic setup = PSEL && !PENABLE;
    wire logic wr = PSEL && PENABLE && PWRITE;
    wire logic hit_lane = DEBUG && PADDR == `CTX_OFF_LANE;
    wire logic hit_sync = DEBUG && PADDR == `CTX_OFF_SYNC;
    wire logic hit_hdr = DEBUG && PADDR == `CTX_OFF_HDR;
    wire logic hit_crc = DEBUG && PADDR == `CTX_OFF_CRC;
    wire logic hit_state = PADDR == `CTX_OFF_STATE;
    wire logic hit_vendor = PADDR == `CTX_OFF_VENDOR;
    wire logic hit_version = PADDR == `CTX_OFF_VERSION;
    wire logic hit_any = hit_lane || hit_sync || hit_hdr || hit_crc || hit_state
        || hit_vendor || hit_version;

    // ----------------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------------
    wire logic [31:0] next_lane = (wr && hit_lane) ? (PWDATA & `CTX_LANE_MASK)
        : LANE_OVERRIDE;
    wire logic [31:0] next_sync = (wr && hit_sync) ? (PWDATA & `CTX_SYNC_MASK)
        : sync_fault_inject_ctrl;
    wire logic [31:0] next_hdr = (wr && hit_hdr) ? (PWDATA & `CTX_HDR_MASK)
        : header_fault_inject_ctrl;
    wire logic [31:0] next_crc = (wr && hit_crc) ? PWDATA : line_checksum_fault_ctrl;
    wire logic tx_change = TX_STATE != prev_tx_state;
    wire logic clear_state = wr && hit_state && PWDATA == 32'h00000000;
    // a state change in the clearing cycle wins over the clear
    wire logic [2:0] next_state = tx_change ? TX_STATE
        : clear_state ? `CTX_STATE_RESET : activity_state;

    // ----------------------------------------------------------------------
    // read selection
    // ----------------------------------------------------------------------
    wire logic [31:0] rd_word =
        hit_lane ? LANE_OVERRIDE :
        hit_sync ? sync_fault_inject_ctrl :
        hit_hdr ? header_fault_inject_ctrl :
        hit_crc ? line_checksum_fault_ctrl :
        hit_state ? {29'h00000000, activity_state} :
        hit_vendor ? VENDOR_CODE :
        hit_version ? VERSION_CODE : 32'h00000000;

    // ----------------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------------
    always_ff @(posedge CLK)
        if (RST)
        begin
            LANE_OVERRIDE <= `CTX_REG_RESET;
            sync_fault_inject_ctrl <= `CTX_REG_RESET;
            header_fault_inject_ctrl <= `CTX_REG_RESET;
            line_checksum_fault_ctrl <= `CTX_REG_RESET;
        end
        else if (CE)
        begin
            LANE_OVERRIDE <= next_lane;
            sync_fault_inject_ctrl <= next_sync;
            header_fault_inject_ctrl <= next_hdr;
            line_checksum_fault_ctrl <= next_crc;
        end

    always_ff @(posedge CLK)
        if (RST)
        begin
            activity_state <= `CTX_STATE_RESET;
            prev_tx_state <= `CTX_STATE_RESET;
        end
        else if (CE)
        begin
            activity_state <= next_state;
            prev_tx_state <= TX_STATE;
        end

    // ----------------------------------------------------------------------
    // register port answer
    // ----------------------------------------------------------------------
    always_ff @(posedge CLK)
        if (RST)
        begin
            PRDATA <= 32'h00000000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else if (CE)
        begin
            PREADY <= setup;
            PSLVERR <= setup && !hit_any;
            if (setup && !PWRITE)
                PRDATA <= rd_word;
        end

    // ----------------------------------------------------------------------
    // fault injector
    // ----------------------------------------------------------------------
    ctx_fault_inject #(
        .LANES(LANES)
    ) u_inject (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .debug_en(DEBUG),
        .sync_ctrl(sync_fault_inject_ctrl),
        .hdr_ctrl(header_fault_inject_ctrl),
        .crc_ctrl(line_checksum_fault_ctrl),
        .pkt_in(PKT_IN),
        .pkt_out(PKT_OUT)
    );

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence read_setup(logic [7:0] a);
        CE && PSEL && !PENABLE && !PWRITE && PADDR == a;
    endsequence

    sequence write_access(logic [7:0] a);
        CE && PSEL && PENABLE && PWRITE && PADDR == a;
    endsequence

    lane_write_mask_a: assert property (write_access(`CTX_OFF_LANE) ##0 DEBUG
        |=> LANE_OVERRIDE == ($past(PWDATA) & 32'h1C71C71C))
        else $error("lane override does not hold written bits");
    lane_reserved_a: assert property ((LANE_OVERRIDE & 32'hE38E38E3) == 32'h0)
        else $error("reserved lane override bits set");
    sync_write_a: assert property (write_access(`CTX_OFF_SYNC) ##0 DEBUG
        |=> sync_fault_inject_ctrl[30:27] == $past(PWDATA[30:27]))
        else $error("lane 4 sync flip index not stored");
    state_clear_a: assert property (write_access(`CTX_OFF_STATE) ##0 PWDATA == 32'h0
        ##0 TX_STATE == prev_tx_state |=> activity_state == 3'h0)
        else $error("zero write did not clear activity state");
    state_follow_a: assert property (CE && TX_STATE != prev_tx_state
        |=> activity_state == $past(TX_STATE))
        else $error("activity state missed a change");
    vendor_read_a: assert property (read_setup(`CTX_OFF_VENDOR)
        |=> PREADY && PRDATA == VENDOR_CODE && !PSLVERR)
        else $error("vendor word read wrong");
    version_read_a: assert property (read_setup(`CTX_OFF_VERSION)
        |=> PREADY && PRDATA == VERSION_CODE)
        else $error("version word read wrong");
    debug_absent_a: assert property (read_setup(`CTX_OFF_CRC) ##0 !DEBUG
        |=> PSLVERR && PRDATA == 32'h0)
        else $error("fault register answered without debug option");
    sync_flip_a: assert property (CE && DEBUG && PKT_IN.kind == ctx_pkg::CTX_KIND_FS
        && sync_fault_inject_ctrl[7:0] == 8'h79
        |=> PKT_OUT.sync[0] == ($past(PKT_IN.sync[0]) ^ 16'h8000))
        else $error("lane 1 start sync bit 15 not inverted");
    header_line_one_a: assert property (CE && DEBUG && PKT_IN.kind == ctx_pkg::CTX_KIND_LP
        && PKT_IN.line == 16'h0 && header_fault_inject_ctrl[17:12] == 6'h01
        |=> PKT_OUT.hdr == ($past(PKT_IN.hdr) ^ 32'h00000002))
        else $error("first line header flip misplaced");
endmodule

// ### rtl/ctx_map.svh
/*
 * Register map, field positions, reset values and fixed masks of the
 * transmitter debug and fault-injection register group.
 * Assumes inclusion by bare name from the register and injection modules.
 */
`ifndef CTX_MAP_SVH
`define CTX_MAP_SVH

// Operation
// - lanes 3 and 4 have force, positive and negative level bits at 20-22, 26-28.
// - lane 2 negative level at bit 16; bits 19:17, 25:23, 31:29 read zero.
// - a requested sync fault inverts one bit of the lane's 16-bit sync code.
// - each lane owns one sync-fault byte: start, end, line enables, 4-bit index.
// - the 4-bit index picks the sync bit to invert; 15 is the top bit.
// - line-packet sync faults hit only the first video line of each frame.
// - override and fault registers exist only when the debug option is built.
// - header-fault register holds 5-bit index and error-force bit for five targets.
// - nonzero header index n inverts header bit n; zero flips nothing.
// - header error-force inverts header bits 0 and 31 together.
// - checksum-fault bit n corrupts checksum of line n, counted from 0.
// - state field codes idle, start, end, line, low-power entry, low-power mode.
// - writing an all-zero word to the state register clears it.
// - read-only word at 0xFC returns the fixed vendor code.
// - read-only word returns the release version code at its own offset.
// - clock lane force bit 2, levels 3 and 4; lane 1 uses bits 8-10.

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define CTX_OFF_LANE 8'h34
`define CTX_OFF_SYNC 8'h38
`define CTX_OFF_HDR 8'h3C
`define CTX_OFF_CRC 8'h40
`define CTX_OFF_STATE 8'h80
`define CTX_OFF_VERSION 8'hF8
`define CTX_OFF_VENDOR 8'hFC

// ----------------------------------------------------------------------
// writable bits and reset values
// ----------------------------------------------------------------------
`define CTX_LANE_MASK 32'h1C71C71C
`define CTX_SYNC_MASK 32'h7F7F7F7F
`define CTX_HDR_MASK 32'h3FFFFFFF
`define CTX_REG_RESET 32'h00000000
`define CTX_STATE_RESET 3'h0

// ----------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------
`define CTX_SYNC_LANE_W 8
`define CTX_SYNC_FS_BIT 0
`define CTX_SYNC_FE_BIT 1
`define CTX_SYNC_LP_BIT 2
`define CTX_SYNC_IDX_LSB 3
`define CTX_HDR_TGT_W 6
`define CTX_HDR_HE_BIT 5
`define CTX_HDR_ERR_MASK 32'h80000001
`define CTX_HDR_LINE_ONE 16'h0000
`define CTX_HDR_LINE_THREE 16'h0002
`define CTX_HDR_LINE_FOUR 16'h0003
`define CTX_FIRST_LINE 16'h0000
`define CTX_CRC_LINES 16'h0020
`define CTX_CRC_FLIP 16'hFFFF

`endif

// ### rtl/ctx_pkg.sv
/*
 * Types shared by the register block and the fault injector.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ctx_pkg;

    // packet kind, one-hot
    typedef enum logic [2:0] {
        CTX_KIND_FS = 3'b001,
        CTX_KIND_FE = 3'b010,
        CTX_KIND_LP = 3'b100
    } ctx_kind_e;

    // transmitter activity codes
    typedef enum logic [2:0] {
        CTX_ST_IDLE = 3'h0,
        CTX_ST_FS = 3'h1,
        CTX_ST_FE = 3'h2,
        CTX_ST_LP = 3'h3,
        CTX_ST_ULP_ENTRY = 3'h4,
        CTX_ST_ULP = 3'h5
    } ctx_state_e;

    // one packet's protected fields, header already carrying its code
    typedef struct packed {
        logic valid;
        ctx_kind_e kind;
        logic [15:0] line;
        logic [31:0] hdr;
        logic [3:0][15:0] sync;
        logic [15:0] crc;
    } ctx_pkt_s;

endpackage

// ### rtl/ctx_fault_inject.sv
/*
 * Fault injector: corrupts sync codes, packet header and line checksum of
 * one packet per valid cycle, registered by one cycle.
 * Assumes the header arrives with its error code already computed.
 */
`timescale 1ns/100ps
`include "ctx_map.svh"

module ctx_fault_inject #(
    parameter int LANES = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic debug_en,
    input wire logic [31:0] sync_ctrl,
    input wire logic [31:0] hdr_ctrl,
    input wire logic [31:0] crc_ctrl,
    input wire ctx_pkg::ctx_pkt_s pkt_in,
    output ctx_pkg::ctx_pkt_s pkt_out
);

    // header mask for one target: single flip plus forced double error
    function automatic logic [31:0] hdr_mask(input logic [5:0] tgt);
        logic [31:0] m;
        m = (tgt[4:0] != 5'h00) ? (32'h00000001 << tgt[4:0]) : 32'h00000000;
        if (tgt[`CTX_HDR_HE_BIT])
            m = m | `CTX_HDR_ERR_MASK;
        return m;
    endfunction

    wire logic is_fs = pkt_in.kind == ctx_pkg::CTX_KIND_FS;
    wire logic is_fe = pkt_in.kind == ctx_pkg::CTX_KIND_FE;
    wire logic is_lp = pkt_in.kind == ctx_pkg::CTX_KIND_LP;
    wire logic first_line = is_lp && pkt_in.line == `CTX_FIRST_LINE;
    wire logic [5:0] hdr_tgt =
        is_fs ? hdr_ctrl[5:0] :
        is_fe ? hdr_ctrl[11:6] :
        first_line ? hdr_ctrl[17:12] :
        (is_lp && pkt_in.line == `CTX_HDR_LINE_THREE) ? hdr_ctrl[23:18] :
        (is_lp && pkt_in.line == `CTX_HDR_LINE_FOUR) ? hdr_ctrl[29:24] : 6'h00;
    wire logic [31:0] hdr_flip = debug_en ? hdr_mask(hdr_tgt) : 32'h00000000;
    wire logic crc_hit = debug_en && is_lp && pkt_in.line < `CTX_CRC_LINES
        && crc_ctrl[pkt_in.line[4:0]];
    logic [3:0][15:0] sync_flip;

    always_comb
    begin
        for (int l = 0; l < 4; l++)
        begin
            logic [7:0] f;
            f = sync_ctrl[l*`CTX_SYNC_LANE_W +: `CTX_SYNC_LANE_W];
            sync_flip[l] = 16'h0000;
            if (debug_en && l < LANES && ((is_fs && f[`CTX_SYNC_FS_BIT])
                || (is_fe && f[`CTX_SYNC_FE_BIT])
                || (first_line && f[`CTX_SYNC_LP_BIT])))
                sync_flip[l] = 16'h0001 << f[`CTX_SYNC_IDX_LSB +: 4];
        end
    end

    // ----------------------------------------------------------------------
    // output register
    // ----------------------------------------------------------------------
    always_ff @(posedge clk)
        if (rst)
            pkt_out <= '0;
        else if (ce)
        begin
            pkt_out <= pkt_in;
            pkt_out.hdr <= pkt_in.hdr ^ hdr_flip;
            pkt_out.sync <= pkt_in.sync ^ sync_flip;
            pkt_out.crc <= crc_hit ? pkt_in.crc ^ `CTX_CRC_FLIP : pkt_in.crc;
        end

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    header_error_force_a: assert property (ce && debug_en && is_fe
        && hdr_ctrl[11:6] == 6'h20 |=> pkt_out.hdr == ($past(pkt_in.hdr) ^ 32'h80000001))
        else $error("forced header error did not flip bits 0 and 31");
    header_index_a: assert property (ce && debug_en && is_fs && !hdr_ctrl[5]
        |=> pkt_out.hdr == ($past(pkt_in.hdr) ^ ($past(hdr_ctrl[4:0]) == 5'h00 ? 32'h0
        : 32'h00000001 << $past(hdr_ctrl[4:0]))))
        else $error("frame start header flip index misapplied");
    sync_first_line_a: assert property (ce && is_lp && pkt_in.line != `CTX_FIRST_LINE
        |=> pkt_out.sync == $past(pkt_in.sync))
        else $error("sync code corrupted on a later line");
    crc_line_a: assert property (ce && debug_en && is_lp && pkt_in.line == 16'h0008
        && crc_ctrl[8] |=> pkt_out.crc == ~$past(pkt_in.crc))
        else $error("checksum of selected line not corrupted");
endmodule

// ### bench/ctx_rx_model.sv
/*
 * Receiver-side model: counts the packets that leave the fault injector.
 * Assumes the packet struct of ctx_pkg and the bench's clock and reset.
 */
`timescale 1ns/100ps

module ctx_rx_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // packets from the transmitter
    input wire ctx_pkg::ctx_pkt_s pkt,
    output logic [15:0] rx_count
);
    // ----------------------------------------------------------------
    // packet counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            rx_count <= 16'h0000;
        else if (pkt.valid)
            rx_count <= rx_count + 16'h0001;
    end
endmodule

// ### bench/testbench.sv
/*
 * Self-checking bench of the debug register group and fault injector.
 * Assumes ctx_pkg, ctx_debug_regs and ctx_rx_model are compiled first.
 */
`timescale 1ns/100ps

module testbench;
    // arbitrary identity values
    localparam logic [31:0] VEND = 32'h00005A5A;
    localparam logic [31:0] VERS = 32'h00010000;
    logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, nd_err, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, lane_ov, nd_rdata, q;
    logic [2:0] tx_state;
    logic [15:0] rx_count;
    ctx_pkg::ctx_pkt_s pkt_in, pkt_out;
    int fails, checks, sent;

    // ----------------------------------------------------------------
    // instances
    // ----------------------------------------------------------------
    ctx_debug_regs #(.LANES(4), .DEBUG(1'b1), .VENDOR_CODE(VEND), .VERSION_CODE(VERS)) dut_u (
        .CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TX_STATE(tx_state), .PKT_IN(pkt_in), .PKT_OUT(pkt_out),
        .LANE_OVERRIDE(lane_ov));
    ctx_debug_regs #(.LANES(4), .DEBUG(1'b0), .VENDOR_CODE(VEND), .VERSION_CODE(VERS)) dut_nd (
        .CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(nd_rdata), .PREADY(),
        .PSLVERR(nd_err), .TX_STATE(tx_state), .PKT_IN(pkt_in), .PKT_OUT(),
        .LANE_OVERRIDE());
    ctx_rx_model rx_u (.clk(clk), .rst(rst), .pkt(pkt_out), .rx_count(rx_count));

    // ----------------------------------------------------------------
    // compare and bus tasks
    // ----------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pkt(input ctx_pkg::ctx_pkt_s got, input ctx_pkg::ctx_pkt_s exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 4);
        if (n >= 4)
            chk_word({31'h0, pready}, 32'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one packet in, faults expected as xor masks on sync, header and checksum
    task automatic send(input ctx_pkg::ctx_kind_e k, input logic [15:0] ln,
        input logic [63:0] sx, input logic [31:0] hx, input logic [15:0] cx);
        ctx_pkg::ctx_pkt_s p, x;
        p = '0;
        p.valid = 1'b1;
        p.kind = k;
        p.line = ln;
        p.hdr = 32'h5A3C96E1;
        p.sync = 64'h1234_5678_9ABC_DEF0;
        p.crc = 16'hA5C3;
        x = p;
        x.sync = p.sync ^ sx;
        x.hdr = p.hdr ^ hx;
        x.crc = p.crc ^ cx;
        @(posedge clk);
        pkt_in <= p;
        @(posedge clk);
        pkt_in <= '0;
        sent++;
        #1;
        chk_pkt(pkt_out, x);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] a [4] = '{8'h34, 8'h38, 8'h3C, 8'h40};
        logic [31:0] m [4] = '{32'h1C71C71C, 32'h7F7F7F7F, 32'h3FFFFFFF, 32'hFFFFFFFF};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, a[i], 32'h0);
            chk_word(q, 32'h0);
            chk_word({31'h0, nd_err}, 32'h1);
            apb(1'b1, a[i], 32'hFFFFFFFF);
            apb(1'b0, a[i], 32'h0);
            chk_word(q, m[i]);
            if (i == 0)
                chk_word(lane_ov, 32'h1C71C71C);
            apb(1'b1, a[i], 32'h0);
        end
        $display("test regs done");
    endtask

    task automatic t_sync();
        apb(1'b1, 8'h38, 32'h00000479);
        send(ctx_pkg::CTX_KIND_FS, 16'h0000, 64'h8000, 32'h0, 16'h0);
        send(ctx_pkg::CTX_KIND_FE, 16'h0000, 64'h0, 32'h0, 16'h0);
        send(ctx_pkg::CTX_KIND_LP, 16'h0000, 64'h10000, 32'h0, 16'h0);
        send(ctx_pkg::CTX_KIND_LP, 16'h0001, 64'h0, 32'h0, 16'h0);
        apb(1'b1, 8'h38, 32'h0);
        $display("test sync done");
    endtask

    task automatic t_hdr();
        apb(1'b1, 8'h3C, 32'h007C1801);
        send(ctx_pkg::CTX_KIND_FS, 16'h0000, 64'h0, 32'h00000002, 16'h0);
        send(ctx_pkg::CTX_KIND_FE, 16'h0000, 64'h0, 32'h80000001, 16'h0);
        send(ctx_pkg::CTX_KIND_LP, 16'h0002, 64'h0, 32'h80000000, 16'h0);
        send(ctx_pkg::CTX_KIND_LP, 16'h0000, 64'h0, 32'h00000002, 16'h0);
        send(ctx_pkg::CTX_KIND_LP, 16'h0003, 64'h0, 32'h0, 16'h0);
        apb(1'b1, 8'h3C, 32'h0);
        $display("test header done");
    endtask

    task automatic t_crc();
        apb(1'b1, 8'h40, 32'h01010101);
        send(ctx_pkg::CTX_KIND_LP, 16'h0008, 64'h0, 32'h0, 16'hFFFF);
        send(ctx_pkg::CTX_KIND_LP, 16'h0001, 64'h0, 32'h0, 16'h0);
        apb(1'b1, 8'h40, 32'h0);
        send(ctx_pkg::CTX_KIND_LP, 16'h0000, 64'h0, 32'h0, 16'h0);
        $display("test checksum done");
    endtask

    task automatic t_state();
        for (int s = 0; s < 6; s++)
        begin
            @(posedge clk);
            tx_state <= 3'(s);
            // let the state register take the change before the read setup
            @(posedge clk);
            apb(1'b0, 8'h80, 32'h0);
            chk_word(q, 32'(s));
        end
        apb(1'b1, 8'h80, 32'h00000001);
        apb(1'b0, 8'h80, 32'h0);
        chk_word(q, 32'h5);
        apb(1'b1, 8'h80, 32'h00000000);
        apb(1'b0, 8'h80, 32'h0);
        chk_word(q, 32'h0);
        $display("test state done");
    endtask

    task automatic t_ident();
        apb(1'b1, 8'hFC, 32'hFFFFFFFF);
        apb(1'b0, 8'hFC, 32'h0);
        chk_word(q, VEND);
        chk_word(nd_rdata, VEND);
        apb(1'b0, 8'hF8, 32'h0);
        chk_word(q, VERS);
        apb(1'b0, 8'h44, 32'h0);
        chk_word({31'h0, e}, 32'h1);
        chk_word(q, 32'h0);
        $display("test ident done");
    endtask

    task automatic give_verdict();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #50000;
        fails++;
        give_verdict();
    end

    initial
    begin
        {rst, ce, psel, penable, pwrite} = 5'b11000;
        paddr = 8'h00;
        pwdata = 32'h0;
        tx_state = 3'h0;
        pkt_in = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_sync();
        t_hdr();
        t_crc();
        t_state();
        t_ident();
        repeat (2) @(posedge clk);
        chk_word({16'h0, rx_count}, 32'(sent));
        give_verdict();
    end
endmodule
